// ===== core/icsc_pkg.sv
package icsc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [5:0] CTRL_OFFSET    = 6'h00;
  localparam logic [5:0] STATUS_OFFSET  = 6'h04;

  // ==========================================================================
  // Control register field positions
  localparam int ONES_LSB               = 26;
  localparam int ONES_W                 = 6;
  localparam int GAME_BASE_LSB          = 24;
  localparam int GPIO_IN_LSB            = 20;
  localparam int GPIO_OUT_LSB           = 16;
  localparam int FMT_BIT                = 15;
  localparam int WARM_RST_BIT           = 14;
  localparam int REC_STOP_BIT           = 13;
  localparam int PWR_MASK_BIT           = 12;
  localparam int REC_SRC_BIT            = 11;
  localparam int VOICE_MASK_BIT         = 10;
  localparam int CURRENT_POWERDOWN_LEVEL_LSB              = 8;
  localparam int MEM_BLOCK_BIT          = 7;
  localparam int FM_EN_BIT              = 6;
  localparam int WAVE_EN_BIT            = 5;
  localparam int REC_EN_BIT             = 4;
  localparam int UART_EN_BIT            = 3;
  localparam int GAME_EN_BIT            = 2;
  localparam int XTAL_GATE_BIT          = 1;
  localparam int PCI_GATE_BIT           = 0;

  // ==========================================================================
  // Reset values and widths
  localparam int GPIO_W                 = 4;
  localparam logic [31:0] CTRL_RESET    = 32'hfc0f_0000;
  localparam logic [31:0] CTRL_WMASK    = 32'h03_0f_ffff;
  localparam logic [3:0]  GPIO_OUT_RST  = 4'hf;
  localparam logic [31:0] STATUS_ONES   = 32'h7fff_fe00;
  localparam int STATUS_IRQ_BIT         = 31;
  localparam int STATUS_PWR_BIT         = 5;
  localparam int STATUS_VOICE_BIT       = 4;

  // Game port bases, indexed by the two-bit select field
  localparam logic [15:0] GAME_BASE_0   = 16'h0200;
  localparam logic [15:0] GAME_BASE_STEP = 16'h0008;

  // Warm codec reset pulse: held at least 1 us
  localparam int CLK_MHZ                = 100;
  localparam int WARM_RST_NS            = 1000;
  localparam int WARM_RST_CYC           = (WARM_RST_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    WR_IDLE  = 3'b001,
    WR_PULSE = 3'b010,
    WR_WAIT  = 3'b100
  } icsc_warm_state_type;

endpackage : icsc_pkg

// ===== core/icsc_warm_reset.sv
`timescale 1ns/1ps
// Stretches a control bit rise into a sync pulse of fixed least width.
module icsc_warm_reset (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ctl_i,
  output logic      sync_o
);
  import icsc_pkg::*;

  typedef struct packed {
    icsc_warm_state_type st;
    logic [15:0]         cnt;
    logic                prev;
  } icsc_wr_type;

  icsc_wr_type s_r;
  icsc_wr_type s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.prev = ctl_i;
    unique case (s_r.st)
      WR_IDLE: begin
        if (ctl_i && !s_r.prev) begin
          s_nxt.st  = WR_PULSE;
          s_nxt.cnt = 16'(WARM_RST_CYC - 1);
        end
      end
      WR_PULSE: begin
        if (s_r.cnt == 16'h0000) begin
          s_nxt.st = WR_WAIT;
        end else begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end
      end
      WR_WAIT: begin
        // Pulse only repeats after software lowers the bit again
        if (!ctl_i) begin
          s_nxt.st = WR_IDLE;
        end
      end
      default: s_nxt.st = WR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{st: WR_IDLE, cnt: 16'h0000, prev: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_o = (s_r.st == WR_PULSE);
endmodule : icsc_warm_reset

// ===== core/icsc_ctrl.sv
`timescale 1ns/1ps
// Contract
// [RQ1] Byte, word, longword writes at offset zero
// [RQ2] Power-on value with outputs high, enables clear
// [RQ3] Top six bits read ones, ignore writes
// [RQ4] Two-bit select picks game port base
// [RQ5] Input field reads live pin levels
// [RQ6] Output bit low drives pin low
// [RQ7] Format bit selects serial framing style
// [RQ8] Warm codec reset from control bit
// [RQ9] Record stop blocks record transfers
// [RQ10] Power mask enables power-change interrupt
// [RQ11] Record source: codec ADC or I2S
// [RQ12] Voice mask enables voice interrupts
// [RQ13] Interrupt while power state differs
// [RQ14] Software matches level to clear interrupt
// [RQ15] Test bit blocks internal memory access
// [RQ16] Three channel enable bits
// [RQ17] Channel restarts on low-then-high enable
// [RQ18] UART enable bit
// [RQ19] Game port enable bit
// [RQ20] Crystal clock gate bit
// [RQ21] Host bus clock gate, except here
// [RQ22] Power interrupt on INTA only if enabled
// [RQ23] Summary flag at status bit 31
// [RQ24] Sources tracked regardless of mask; status bit 4 shows voice only while the voice mask bit is set
module icsc_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register access
  input  wire logic [5:0]  addr_i,
  input  wire logic        wr_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [31:0] wdata_i,
  output logic [31:0]      rdata_o,
  // Power state from configuration space
  input  wire logic [1:0]  cfg_power_state_i,
  // Interrupt sources
  input  wire logic        voice_irq_i,
  input  wire logic        fm_irq_i,
  input  wire logic        wave_irq_i,
  input  wire logic        rec_irq_i,
  input  wire logic        uart_irq_i,
  input  wire logic [1:0]  voice_code_i,
  input  wire logic        codec_sync_err_i,
  output logic             inta_n_o,
  // General purpose pins
  input  wire logic [3:0]  gpio_i,
  output logic [3:0]       gpio_o,
  output logic [3:0]       gpio_oe_o,
  // Controls to the rest of the chip
  output logic [15:0]      game_port_base_o,
  output logic             compressed_audio_serial_format_o,
  output logic             codec_warm_reset_o,
  output logic             record_stop_o,
  output logic             record_source_select_o,
  output logic             memory_bus_block_test_o,
  output logic             fm_playback_enable_o,
  output logic             wave_playback_enable_o,
  output logic             record_enable_o,
  output logic             fm_restart_o,
  output logic             wave_restart_o,
  output logic             record_restart_o,
  output logic             uart_enable_o,
  output logic             game_port_enable_o,
  output logic             crystal_clock_gate_o,
  output logic             host_bus_clock_gate_o
);
  import icsc_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0]  restart;
    logic [31:0] rdata;
    logic        irq;
  } icsc_state_type;

  icsc_state_type s_r;
  icsc_state_type s_nxt;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  logic [31:0] wmask;
  logic        pwr_pending;
  logic        voice_pending;
  logic        any_pending;
  logic [31:0] status_view;
  logic [31:0] ctrl_view;
  logic [2:0]  en_old;
  logic [2:0]  en_new;

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    // [RQ1] byte lane writes
    // [RQ3] top bits protected
    wmask = be_mask(be_i) & CTRL_WMASK;
    if (wr_i && addr_i == CTRL_OFFSET) begin
      s_nxt.ctrl = (s_r.ctrl & ~wmask) | (wdata_i & wmask);
    end
    // [RQ17] restart on low-then-high
    en_old = {s_r.ctrl[FM_EN_BIT], s_r.ctrl[WAVE_EN_BIT], s_r.ctrl[REC_EN_BIT]};
    en_new = {s_nxt.ctrl[FM_EN_BIT], s_nxt.ctrl[WAVE_EN_BIT], s_nxt.ctrl[REC_EN_BIT]};
    s_nxt.restart = en_new & ~en_old;

    // [RQ13] level mismatch interrupt
    pwr_pending = (cfg_power_state_i != s_r.ctrl[CURRENT_POWERDOWN_LEVEL_LSB +: 2]);
    // [RQ24] sources tracked unmasked
    voice_pending = voice_irq_i;
    // [RQ23] summary of all sources
    any_pending = pwr_pending | voice_pending | fm_irq_i | wave_irq_i
                | rec_irq_i | uart_irq_i;
    // [RQ10] power mask gating
    // [RQ22] INTA only while enabled
    // [RQ12] voice mask gating
    s_nxt.irq = (pwr_pending & s_r.ctrl[PWR_MASK_BIT])
              | (voice_pending & s_r.ctrl[VOICE_MASK_BIT])
              | fm_irq_i | wave_irq_i | rec_irq_i | uart_irq_i;

    status_view = STATUS_ONES;
    status_view[STATUS_IRQ_BIT]   = any_pending;
    status_view[8]                = codec_sync_err_i;
    status_view[7:6]              = voice_code_i;
    status_view[STATUS_PWR_BIT]   = pwr_pending;
    status_view[STATUS_VOICE_BIT] = voice_pending & s_r.ctrl[VOICE_MASK_BIT];
    status_view[3:0] = {uart_irq_i, fm_irq_i, wave_irq_i, rec_irq_i};

    ctrl_view = s_r.ctrl;
    // [RQ3] read as ones
    ctrl_view[ONES_LSB +: ONES_W] = '1;
    // [RQ5] live pin levels
    ctrl_view[GPIO_IN_LSB +: GPIO_W] = gpio_i;

    unique case (addr_i)
      CTRL_OFFSET:   s_nxt.rdata = ctrl_view;
      STATUS_OFFSET: s_nxt.rdata = status_view;
      default:       s_nxt.rdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // [RQ2] power-on value
      s_r <= '{ctrl: CTRL_RESET, restart: 3'h0, rdata: 32'h0000_0000, irq: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  icsc_warm_reset u_warm (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    // [RQ8] warm reset pulse
    .ctl_i  (s_r.ctrl[WARM_RST_BIT]),
    .sync_o (codec_warm_reset_o)
  );

  // ==========================================================================
  // Outputs
  assign rdata_o  = s_r.rdata;
  assign inta_n_o = ~s_r.irq;

  // [RQ6] open-drain style low drive
  genvar g;
  generate
    for (g = 0; g < GPIO_W; g++) begin : g_gpio
      assign gpio_o[g]    = 1'b0;
      assign gpio_oe_o[g] = ~s_r.ctrl[GPIO_OUT_LSB + g];
    end
  endgenerate

  // [RQ4] base select
  assign game_port_base_o = GAME_BASE_0
                          + (GAME_BASE_STEP * {14'h0000, s_r.ctrl[GAME_BASE_LSB +: 2]});
  // [RQ7] framing select
  assign compressed_audio_serial_format_o = s_r.ctrl[FMT_BIT];
  // [RQ9] record stop
  assign record_stop_o           = s_r.ctrl[REC_STOP_BIT];
  // [RQ11] record source
  assign record_source_select_o  = s_r.ctrl[REC_SRC_BIT];
  // [RQ15] memory block test
  assign memory_bus_block_test_o = s_r.ctrl[MEM_BLOCK_BIT];
  // [RQ16] channel enables
  assign fm_playback_enable_o    = s_r.ctrl[FM_EN_BIT];
  assign wave_playback_enable_o  = s_r.ctrl[WAVE_EN_BIT];
  assign record_enable_o         = s_r.ctrl[REC_EN_BIT];
  assign fm_restart_o            = s_r.restart[2];
  assign wave_restart_o          = s_r.restart[1];
  assign record_restart_o        = s_r.restart[0];
  // [RQ18] UART enable
  assign uart_enable_o           = s_r.ctrl[UART_EN_BIT];
  // [RQ19] game port enable
  assign game_port_enable_o      = s_r.ctrl[GAME_EN_BIT];
  // [RQ20] crystal gate
  assign crystal_clock_gate_o    = s_r.ctrl[XTAL_GATE_BIT];
  // [RQ21] host clock gate, this block stays clocked
  assign host_bus_clock_gate_o   = s_r.ctrl[PCI_GATE_BIT];
endmodule : icsc_ctrl

// ===== verif/icsc_ctrl_checker.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checks of the control register block
module icsc_ctrl_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [5:0]  addr_i,
  input wire logic        wr_i,
  input wire logic [3:0]  be_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0]  cfg_power_state_i,
  input wire logic        voice_irq_i,
  input wire logic        fm_irq_i,
  input wire logic        wave_irq_i,
  input wire logic        rec_irq_i,
  input wire logic        uart_irq_i,
  input wire logic        inta_n_o,
  input wire logic [3:0]  gpio_i,
  input wire logic [3:0]  gpio_o,
  input wire logic [3:0]  gpio_oe_o,
  input wire logic [15:0] game_port_base_o,
  input wire logic        codec_warm_reset_o,
  input wire logic        fm_playback_enable_o,
  input wire logic        fm_restart_o,
  input wire logic        host_bus_clock_gate_o
);
  logic [7:0] h_r;
  wire        wr0 = wr_i && addr_i == 6'h00;
  // Mirror of bits 15:8: masks, level, warm reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      h_r <= 8'h00;
    end else if (wr0 && be_i[1]) begin
      h_r <= wdata_i[15:8];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_byte0_write: assert property (wr0 && be_i[0] |=>
    {fm_playback_enable_o, host_bus_clock_gate_o} == {$past(wdata_i[6]), $past(wdata_i[0])})
    else $error("byte0 controls wrong");
  a_game_base: assert property (wr0 && be_i[3] |=>
    game_port_base_o == 16'h0200 + {$past(wdata_i[25:24]), 3'b000}) else $error("game base");
  a_ones_read: assert property (!$past(rst_i) && $past(addr_i) == 6'h00 |->
    rdata_o[31:26] == 6'h3f) else $error("top bits not ones");
  a_gpio_live: assert property (!$past(rst_i) && $past(addr_i) == 6'h00 |->
    rdata_o[23:20] == $past(gpio_i)) else $error("gpio input field");
  a_gpio_drive: assert property (wr0 && be_i[2] |=>
    gpio_oe_o == ~$past(wdata_i[19:16]) && (gpio_o & gpio_oe_o) == 4'h0) else $error("gpio");
  a_restart_pulse: assert property (fm_restart_o == $rose(fm_playback_enable_o))
    else $error("restart pulse");
  a_pwr_irq: assert property (h_r[4] && h_r[1:0] != cfg_power_state_i |=> !inta_n_o)
    else $error("power irq missing");
  a_irq_quiet: assert property (!(h_r[4] && h_r[1:0] != cfg_power_state_i) &&
    !(h_r[2] && voice_irq_i) && !(fm_irq_i | wave_irq_i | rec_irq_i | uart_irq_i)
    |=> inta_n_o) else $error("spurious irq");
  a_warm_pulse: assert property ($rose(h_r[6]) |-> ##[0:2] codec_warm_reset_o [*8])
    else $error("warm reset pulse");
endmodule : icsc_ctrl_checker

bind icsc_ctrl icsc_ctrl_checker u_chk (.*);

// ===== verif/icsc_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Host processor issuing direct I/O cycles
module icsc_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  output logic [5:0]       addr_o,
  output logic             wr_o,
  output logic [3:0]       be_o,
  output logic [31:0]      wdata_o
);
  initial begin
    addr_o = 6'h00;
    wr_o = 1'b0;
    be_o = 4'h0;
    wdata_o = 32'h0;
  end
  task automatic wr(input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_i);
    #1;
    {addr_o, be_o, wdata_o, wr_o} = {a, b, d, 1'b1};
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    @(posedge clk_i);
    #1;
    d = rdata_i;
  endtask : rd
endmodule : icsc_host_model

// ===== verif/irq_chip_select_control_tb.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench of the control register block
module irq_chip_select_control_tb;
  import icsc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i, inta_n_o, codec_warm_reset_o, codec_sync_err_i = 1'b0;
  logic [5:0] addr_i;
  logic [3:0] be_i, gpio_o, gpio_oe_o, gpio_i = 4'h5;
  logic [31:0] wdata_i, rdata_o, rd_v;
  logic [1:0] cfg_power_state_i = 2'b00, voice_code_i = 2'b01;
  logic voice_irq_i, fm_irq_i, wave_irq_i, rec_irq_i, uart_irq_i;
  logic [15:0] game_port_base_o;
  logic compressed_audio_serial_format_o, record_stop_o, record_source_select_o;
  logic memory_bus_block_test_o, fm_playback_enable_o, wave_playback_enable_o;
  logic record_enable_o, uart_enable_o, game_port_enable_o, crystal_clock_gate_o;
  logic host_bus_clock_gate_o, fm_restart_o, wave_restart_o, record_restart_o;
  logic [4:0] src = 5'h00;
  int   mismatches = 0;
  int   n_tests = 0;
  wire [10:0] lvl = {compressed_audio_serial_format_o, record_stop_o, record_source_select_o,
    memory_bus_block_test_o, fm_playback_enable_o, wave_playback_enable_o, record_enable_o,
    uart_enable_o, game_port_enable_o, crystal_clock_gate_o, host_bus_clock_gate_o};
  wire [2:0]  rst3 = {fm_restart_o, wave_restart_o, record_restart_o};
  assign {voice_irq_i, fm_irq_i, wave_irq_i, rec_irq_i, uart_irq_i} = src;
  always #5 clk_i = ~clk_i;
  icsc_ctrl u_dut (.*);
  icsc_host_model u_host (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wr_o(wr_i),
    .be_o(be_i), .wdata_o(wdata_i));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic t_regs();
    u_host.rd(CTRL_OFFSET, rd_v);
    chk("reset", rd_v, 32'hfc5f_0000);
    chk("reset outs", {gpio_oe_o, inta_n_o, lvl}, {4'h0, 1'b1, 11'h000});
    u_host.wr(CTRL_OFFSET, 4'h1, 32'hffff_ffff);
    u_host.wr(CTRL_OFFSET, 4'h6, 32'hff03_a800);
    gpio_i = 4'ha;
    u_host.rd(CTRL_OFFSET, rd_v);
    chk("bytes", rd_v, 32'hfca3_a8ff);
    chk("levels", {gpio_oe_o, lvl}, {4'hc, 11'h7ff});
    chk("gpio drive", {28'h0000000, gpio_o}, 32'h0000_0000);
    u_host.wr(STATUS_OFFSET, 4'hf, 32'h0);
    u_host.wr(6'h3c, 4'hf, 32'h0);
    u_host.rd(6'h3c, rd_v);
    chk("unmapped", rd_v, 32'h0000_0000);
    chk("unmapped levels", {21'h000000, lvl}, {21'h000000, 11'h7ff});
    u_host.wr(CTRL_OFFSET, 4'hf, 32'hffff_0000);
    u_host.rd(CTRL_OFFSET, rd_v);
    chk("longword", rd_v, 32'hffaf_0000);
    chk("longword outs", {17'h00000, lvl, gpio_oe_o}, {17'h00000, 11'h000, 4'h0});
    for (int i = 0; i < 4; i++) begin
      u_host.wr(CTRL_OFFSET, 4'h8, {6'h00, 2'(i), 24'h0});
      chk("game base", game_port_base_o, 16'h0200 + 16'(8 * i));
    end
    $display("t_regs done");
  endtask : t_regs
  task automatic t_irq();
    cfg_power_state_i = 2'b10;
    settle();
    chk("pwr masked", inta_n_o, 1'b1);
    u_host.wr(CTRL_OFFSET, 4'h2, 32'h0000_1000);
    settle();
    chk("pwr irq", inta_n_o, 1'b0);
    u_host.wr(CTRL_OFFSET, 4'h2, 32'h0000_1200);
    src = 5'h10;
    settle();
    chk("voice masked", inta_n_o, 1'b1);
    u_host.wr(CTRL_OFFSET, 4'h2, 32'h0000_1600);
    settle();
    chk("voice irq", inta_n_o, 1'b0);
    src = 5'h01;
    u_host.rd(STATUS_OFFSET, rd_v);
    chk("summary", {rd_v[31], rd_v[3], inta_n_o}, 3'b110);
    chk("status", rd_v, 32'hffff_fe48);
    src = 5'h00;
    cfg_power_state_i = 2'b00;
    settle();
    chk("pwr change", inta_n_o, 1'b0);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_restart();
    int w;
    w = 0;
    u_host.wr(CTRL_OFFSET, 4'h1, 32'h40);
    chk("restart fm", rst3, 3'b100);
    u_host.wr(CTRL_OFFSET, 4'h1, 32'h30);
    chk("restart two", rst3, 3'b011);
    u_host.wr(CTRL_OFFSET, 4'h3, 32'h4030);
    chk("no restart", rst3, 3'b000);
    repeat (300) begin
      @(posedge clk_i);
      #1;
      w += int'(codec_warm_reset_o === 1'b1);
    end
    chk("warm width", 32'(w), 32'(WARM_RST_CYC));
    $display("t_restart done");
  endtask : t_restart
  // Reset in mid-run must bring back the power-on picture
  task automatic t_reset();
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    chk("reset outs 2", {gpio_oe_o, inta_n_o, lvl}, {4'h0, 1'b1, 11'h000});
    chk("reset warm", codec_warm_reset_o, 1'b0);
    chk("reset restart", rst3, 3'b000);
    u_host.rd(CTRL_OFFSET, rd_v);
    chk("reset 2", rd_v, 32'hfcaf_0000);
    $display("t_reset done");
  endtask : t_reset
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_regs();
    t_irq();
    t_restart();
    t_reset();
    end_of_test();
  end
endmodule : irq_chip_select_control_tb
